// ### sector_lock_protection.sv
`include "sector_lock_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module sector_lock_protection #(
  parameter int SECTORS = 16,
  parameter int SUBS = 16,
  parameter int BYTE_PROG_NS = `BYTE_PROG_NS,
  parameter int SECTOR_ERASE_NS = `SECTOR_ERASE_NS,
  parameter int PROG_CYC = (BYTE_PROG_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  parameter int ERASE_CYC = (SECTOR_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
  localparam int SW = $clog2(SECTORS),
  localparam int BW = $clog2(SUBS),
  localparam int VN = SECTORS - 2 + 2 * SUBS,
  localparam int VW = $clog2(VN),
  localparam int CW = $clog2(ERASE_CYC + PROG_CYC + 1)
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic nv_init,
  input wire logic cmd_valid,
  input wire sector_lock_pkg::cmd_op_t cmd_op,
  input wire logic [SW-1:0] cmd_sector,
  input wire logic [BW-1:0] cmd_sub,
  input wire logic [15:0] cmd_data,
  input wire logic pwd_match,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [15:0] rsp_data,
  output logic pwd_wr_ok,
  output logic pwd_locked,
  output logic freeze,
  output logic busy
);
  import sector_lock_pkg::*;

  // ==========================================
  // state
  logic [`PROT_WIDTH-1:0] prot_q;
  logic freeze_q;
  logic [VN-1:0] vwl_q;
  logic [VN-1:0] vld_q;
  state_t state_q;
  cmd_op_t op_q;
  logic [SW-1:0] sec_q;
  logic [VW-1:0] vi_q;
  logic [CW-1:0] cnt_q;
  logic take;
  logic pw_en;
  logic [VW-1:0] vi;

  lock_mem_if #(.IW(SW)) mif ();

  lock_bit_mem #(.N(SECTORS)) u_nv_bits (
    .clk(mclk),
    .m(mif.mem)
  );

  assign take = cmd_valid && cmd_ready;
  assign pw_en = !prot_q[`PROT_PWD_BIT];

  // ==========================================
  // volatile index: end sectors split into subsectors
  function automatic logic [VW-1:0] vol_index(input logic [SW-1:0] s, input logic [BW-1:0] b);
    logic [VW-1:0] r;
    r = '0;
    if (s == '0) begin
      r = VW'(b);
    end else if (s == SW'(SECTORS - 1)) begin
      r = VW'(SUBS) + VW'(b);
    end else begin
      r = VW'(2 * SUBS) + VW'(s) - VW'(1);
    end
    return r;
  endfunction

  assign vi = vol_index(cmd_sector, cmd_sub);

  // ==========================================
  // protection scheme register, one-time bits
  always_ff @(posedge mclk) begin
    if (nv_init) begin
      prot_q <= `PROT_RST;
    end else if (take && cmd_op == OP_WR_PROT) begin
      // clearing both at once is refused outright
      if (!cmd_data[`PROT_PWD_BIT] && cmd_data[`PROT_SPL_BIT] &&
          prot_q[`PROT_SPL_BIT]) begin
        prot_q[`PROT_PWD_BIT] <= 1'b0;
      end
      if (!cmd_data[`PROT_SPL_BIT] && cmd_data[`PROT_PWD_BIT] &&
          prot_q[`PROT_PWD_BIT]) begin
        prot_q[`PROT_SPL_BIT] <= 1'b0;
      end
    end
  end

  // password store lives outside; this only grants the write
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pwd_wr_ok <= 1'b0;
    end else begin
      pwd_wr_ok <= take && cmd_op == OP_WR_PWD && !pw_en;
    end
  end

  always_ff @(posedge mclk) begin
    pwd_locked <= pw_en;
  end

  // ==========================================
  // global freeze bit
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      freeze_q <= !pw_en;
    end else if (take && cmd_op == OP_UNLOCK) begin
      if (!pw_en || pwd_match) begin
        freeze_q <= 1'b1;
      end
    end else if (take && cmd_op == OP_WR_FREEZE) begin
      freeze_q <= 1'b0;
    end
  end

  assign freeze = freeze_q;

  // ==========================================
  // volatile lock and lock-down bits
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      vwl_q <= '0;
      vld_q <= '0;
    end else if (take && cmd_op == OP_WR_VLOCK && !vld_q[vi]) begin
      vwl_q[vi] <= cmd_data[`VLK_WL_BIT];
      vld_q[vi] <= cmd_data[`VLK_LD_BIT];
    end
  end

  // ==========================================
  // sequencer for nv lookups and timed nv program/erase
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      cmd_ready <= 1'b1;
      busy <= 1'b0;
      cnt_q <= '0;
      op_q <= OP_NOP;
      sec_q <= '0;
      vi_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (take) begin
            op_q <= cmd_op;
            sec_q <= cmd_sector;
            vi_q <= vi;
            if (cmd_op == OP_RD_NVLOCK || cmd_op == OP_CHECK) begin
              state_q <= ST_LOOKUP;
              cmd_ready <= 1'b0;
            end else if (freeze_q && cmd_op == OP_WR_NVLOCK) begin
              state_q <= ST_BUSY;
              cmd_ready <= 1'b0;
              busy <= 1'b1;
              cnt_q <= CW'(PROG_CYC - 1);
            end else if (freeze_q && cmd_op == OP_ER_NVLOCK) begin
              state_q <= ST_BUSY;
              cmd_ready <= 1'b0;
              busy <= 1'b1;
              cnt_q <= CW'(ERASE_CYC - 1);
            end
          end
        end
        ST_LOOKUP: begin
          state_q <= ST_IDLE;
          cmd_ready <= 1'b1;
        end
        ST_BUSY: begin
          if (cnt_q == '0) begin
            state_q <= ST_IDLE;
            cmd_ready <= 1'b1;
            busy <= 1'b0;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: begin
          state_q <= ST_IDLE;
          cmd_ready <= 1'b1;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // cell update lands on the last busy cycle
  assign mif.rd_idx = cmd_sector;
  assign mif.wr_idx = sec_q;
  assign mif.init = nv_init;
  assign mif.wr_en = state_q == ST_BUSY && cnt_q == '0 && op_q == OP_WR_NVLOCK;
  assign mif.erase_all = state_q == ST_BUSY && cnt_q == '0 && op_q == OP_ER_NVLOCK;

  // ==========================================
  // responses
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= 1'b0;
      rsp_data <= 16'h0000;
      if (state_q == ST_IDLE && take) begin
        case (cmd_op)
          OP_RD_PROT: begin
            rsp_valid <= 1'b1;
            rsp_data <= prot_q;
          end
          OP_RD_FREEZE: begin
            rsp_valid <= 1'b1;
            rsp_data <= {15'h0000, freeze_q};
          end
          OP_RD_VLOCK: begin
            rsp_valid <= 1'b1;
            rsp_data <= {14'h0000, vld_q[vi], vwl_q[vi]};
          end
          default: begin
            rsp_valid <= 1'b0;
          end
        endcase
      end else if (state_q == ST_LOOKUP) begin
        rsp_valid <= 1'b1;
        if (op_q == OP_CHECK) begin
          rsp_data <= {15'h0000, !mif.rd_bit || vwl_q[vi_q]};
        end else begin
          rsp_data <= {15'h0000, mif.rd_bit};
        end
      end
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // busy cycles so far, for the timing checks only
  logic [CW-1:0] run_q;

  always_ff @(posedge mclk) begin
    if (!rstn || !busy) begin
      run_q <= '0;
    end else begin
      run_q <= run_q + CW'(1);
    end
  end

  a_prot_once:
    assert property (!nv_init |=> (prot_q & ~$past(prot_q)) == 16'h0000)
    else $error("scheme bit returned to one");
  a_prot_excl:
    assert property (prot_q[`PROT_PWD_BIT] || prot_q[`PROT_SPL_BIT])
    else $error("both scheme bits zero");
  a_pwd_frozen:
    assert property (take && cmd_op == OP_WR_PWD && pw_en |=> !pwd_wr_ok)
    else $error("password write granted after lock");
  a_bad_pwd:
    assert property (take && cmd_op == OP_UNLOCK && pw_en && !pwd_match |=> $stable(freeze_q))
    else $error("freeze moved on wrong password");
  a_good_pwd:
    assert property (take && cmd_op == OP_UNLOCK && pwd_match |=> freeze_q)
    else $error("freeze not set by unlock");
  a_freeze_clr:
    assert property (take && cmd_op == OP_WR_FREEZE |=> !freeze_q)
    else $error("freeze not cleared");
  a_freeze_rst:
    assert property ($rose(rstn) && pw_en |-> !freeze_q)
    else $error("freeze not locked after reset");
  a_freeze_read:
    assert property (take && cmd_op == OP_RD_FREEZE |=> rsp_valid && rsp_data == {15'h0000, $past(freeze_q)})
    else $error("freeze read mismatch");
  a_nv_gated:
    assert property (take && !freeze_q && (cmd_op == OP_WR_NVLOCK || cmd_op == OP_ER_NVLOCK)
                     |=> state_q == ST_IDLE && !busy)
    else $error("nv change ran while frozen");
  a_prog_time:
    assert property (take && freeze_q && cmd_op == OP_WR_NVLOCK |=> busy [*2])
    else $error("nv program too short");
  a_lock_down:
    assert property (take && cmd_op == OP_WR_VLOCK && vld_q[vi] |=> $stable(vwl_q) && $stable(vld_q))
    else $error("volatile bits changed under lock-down");
  a_vol_reset:
    assert property ($rose(rstn) |-> vwl_q == '0 && vld_q == '0)
    else $error("volatile bits not cleared by reset");
  a_check_lock:
    assert property (state_q == ST_LOOKUP && op_q == OP_CHECK |=>
                     rsp_valid && rsp_data[0] == (!$past(mif.rd_bit) || $past(vwl_q[vi_q])))
    else $error("check answer wrong");
  a_prog_len:
    assert property (state_q == ST_BUSY && cnt_q == '0 && op_q == OP_WR_NVLOCK |->
                     run_q == CW'(PROG_CYC - 1))
    else $error("nv program length wrong");
  a_erase_len:
    assert property (state_q == ST_BUSY && cnt_q == '0 && op_q == OP_ER_NVLOCK |->
                     run_q == CW'(ERASE_CYC - 1))
    else $error("nv erase length wrong");
  a_pwd_perm:
    assert property (pw_en && !nv_init |=> pw_en)
    else $error("password protection dropped");
  a_scheme_init:
    assert property (nv_init |=> prot_q == `PROT_RST)
    else $error("scheme register not initialised");

  c_unlock: cover property (take && cmd_op == OP_UNLOCK && pw_en && pwd_match);
  c_erase_done: cover property (mif.erase_all);
  c_blocked: cover property (rsp_valid && op_q == OP_CHECK && rsp_data[0]);
  c_lock_down: cover property (take && cmd_op == OP_WR_VLOCK && vld_q[vi]);
  c_pwd_grant: cover property (pwd_wr_ok);
endmodule

`default_nettype wire

// ### sector_lock_defs.svh
`ifndef SECTOR_LOCK_DEFS_SVH
`define SECTOR_LOCK_DEFS_SVH

// ==========================================
// protection scheme register
`define PROT_WIDTH 16
`define PROT_RST 16'hffff
`define PROT_PWD_BIT 2
`define PROT_SPL_BIT 1

// ==========================================
// freeze register and volatile lock register
`define FRZ_WIDTH 8
`define FRZ_BIT 0
`define VLK_WL_BIT 0
`define VLK_LD_BIT 1

// ==========================================
// timing
`define CLK_PERIOD_NS 10
`define BYTE_PROG_NS 1000
`define SECTOR_ERASE_NS 1000000

`endif

// ### sector_lock_pkg.sv
package sector_lock_pkg;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_RD_PROT = 4'h1,
    OP_WR_PROT = 4'h2,
    OP_WR_PWD = 4'h3,
    OP_UNLOCK = 4'h4,
    OP_RD_FREEZE = 4'h5,
    OP_WR_FREEZE = 4'h6,
    OP_WR_NVLOCK = 4'h7,
    OP_ER_NVLOCK = 4'h8,
    OP_RD_NVLOCK = 4'h9,
    OP_WR_VLOCK = 4'ha,
    OP_RD_VLOCK = 4'hb,
    OP_CHECK = 4'hc
  } cmd_op_t;

  // gray along idle -> lookup -> idle only; idle <-> busy flips both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOOKUP = 2'b01,
    ST_BUSY = 2'b11
  } state_t;

endpackage

// ### lock_mem_if.sv
`timescale 1ns/10ps
`default_nettype none

interface lock_mem_if #(
  parameter int IW = 4
);
  logic [IW-1:0] rd_idx;
  logic rd_bit;
  logic wr_en;
  logic [IW-1:0] wr_idx;
  logic erase_all;
  logic init;

  modport ctrl (output rd_idx, wr_en, wr_idx, erase_all, init, input rd_bit);
  modport mem (input rd_idx, wr_en, wr_idx, erase_all, init, output rd_bit);
endinterface

`default_nettype wire

// ### lock_bit_mem.sv
`timescale 1ns/10ps
`default_nettype none

module lock_bit_mem #(
  parameter int N = 16
) (
  input wire logic clk,
  lock_mem_if.mem m
);
  // no reset on purpose: these bits model nonvolatile cells
  logic [N-1:0] bits_q;

  always_ff @(posedge clk) begin
    if (m.init || m.erase_all) begin
      bits_q <= '1;
    end else if (m.wr_en) begin
      bits_q[m.wr_idx] <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    m.rd_bit <= bits_q[m.rd_idx];
  end
endmodule

`default_nettype wire

// ### host_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// host side of the command port
module host_model (
  input wire logic mclk,
  input wire logic cmd_ready,
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  output logic cmd_valid,
  output var sector_lock_pkg::cmd_op_t cmd_op,
  output logic [3:0] cmd_sector,
  output logic [3:0] cmd_sub,
  output logic [15:0] cmd_data,
  output logic pwd_match
);
  import sector_lock_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_op = OP_NOP;
    cmd_sector = 4'h0;
    cmd_sub = 4'h0;
    cmd_data = 16'h0;
    pwd_match = 1'b0;
  end

  // request held until an edge that sees ready
  task automatic send(input cmd_op_t op, input logic [3:0] s, input logic [3:0] b,
      input logic [15:0] d, input logic pm);
    int n;
    @(negedge mclk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_sector = s;
    cmd_sub = b;
    cmd_data = d;
    pwd_match = pm;
    n = 0;
    // ready only moves on rising edges, so read it at the falling one
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
    @(negedge mclk);
    cmd_valid = 1'b0;
    // stale values never look valid
    cmd_data = ~d;
    pwd_match = ~pm;
  endtask

  task automatic rd(input cmd_op_t op, input logic [3:0] s, input logic [3:0] b,
      output logic [16:0] r);
    int n;
    send(op, s, b, 16'h0, 1'b0);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    r = {rsp_valid, rsp_data};
  endtask
endmodule

`default_nettype wire

// ### test_sector_lock_protection.sv
`timescale 1ns/10ps
`default_nettype none

module test_sector_lock_protection;
  import sector_lock_pkg::*;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic nv_init = 1'b1;
  logic cmd_valid, pwd_match, cmd_ready, rsp_valid, pwd_wr_ok, pwd_locked, freeze, busy;
  cmd_op_t cmd_op;
  logic [3:0] cmd_sector, cmd_sub;
  logic [15:0] cmd_data, rsp_data;
  logic [16:0] bc;
  logic ok;
  int mismatches = 0;
  int cmp_count = 0;

  always #5 mclk = ~mclk;

  // short nv timings keep the run brief
  sector_lock_protection #(.PROG_CYC(2), .ERASE_CYC(3)) uut (.mclk, .rstn, .nv_init,
    .cmd_valid, .cmd_op, .cmd_sector, .cmd_sub, .cmd_data, .pwd_match, .cmd_ready,
    .rsp_valid, .rsp_data, .pwd_wr_ok, .pwd_locked, .freeze, .busy);

  host_model host (.mclk, .cmd_ready, .rsp_valid, .rsp_data, .cmd_valid, .cmd_op,
    .cmd_sector, .cmd_sub, .cmd_data, .pwd_match);

  // ==========================================
  // helpers
  task automatic conclude;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rc(input cmd_op_t op, input logic [3:0] s, input logic [3:0] b,
      input logic [15:0] e);
    logic [16:0] r;
    host.rd(op, s, b, r);
    check(r, {1'b1, e});
  endtask

  // counts busy cycles after the take
  task automatic w(input cmd_op_t op, input logic [3:0] s, input logic [3:0] b,
      input logic [15:0] d, input logic pm);
    host.send(op, s, b, d, pm);
    ok = pwd_wr_ok;
    bc = 17'h0;
    while (busy === 1'b1 && bc < 17'h64) begin
      bc++;
      @(negedge mclk);
    end
  endtask

  task automatic rst;
    @(negedge mclk);
    rstn = 1'b0;
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
  endtask

  // ==========================================
  // sequence
  initial begin
    #20000;
    mismatches++;
    conclude();
  end

  initial begin
    repeat (8) @(negedge mclk);
    nv_init = 1'b0;
    rstn = 1'b1;
    rc(OP_RD_PROT, 4'h0, 4'h0, 16'hffff);
    rc(OP_RD_FREEZE, 4'h0, 4'h0, 16'h0001);
    for (int k = 0; k < 16; k++) rc(OP_RD_NVLOCK, 4'(k), 4'h0, 16'h0001);
    rc(OP_RD_VLOCK, 4'h5, 4'h0, 16'h0000);
    rc(OP_CHECK, 4'h3, 4'h0, 16'h0000);
    check({16'h0, pwd_locked}, 17'h0);
    w(OP_WR_PWD, 4'h0, 4'h0, 16'h1234, 1'b0);
    check({16'h0, ok}, 17'h1);
    w(OP_WR_NVLOCK, 4'h3, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h2);
    rc(OP_RD_NVLOCK, 4'h3, 4'h0, 16'h0000);
    rc(OP_RD_NVLOCK, 4'h4, 4'h0, 16'h0001);
    rc(OP_CHECK, 4'h3, 4'h0, 16'h0001);
    w(OP_WR_FREEZE, 4'h0, 4'h0, 16'h0, 1'b0);
    check({16'h0, freeze}, 17'h0);
    rc(OP_RD_FREEZE, 4'h0, 4'h0, 16'h0000);
    w(OP_ER_NVLOCK, 4'h0, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h0);
    w(OP_WR_NVLOCK, 4'h4, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h0);
    rc(OP_RD_NVLOCK, 4'h3, 4'h0, 16'h0000);
    rc(OP_RD_NVLOCK, 4'h4, 4'h0, 16'h0001);
    w(OP_UNLOCK, 4'h0, 4'h0, 16'h0, 1'b0);
    rc(OP_RD_FREEZE, 4'h0, 4'h0, 16'h0001);
    w(OP_ER_NVLOCK, 4'h0, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h3);
    rc(OP_RD_NVLOCK, 4'h3, 4'h0, 16'h0001);
    w(OP_WR_NVLOCK, 4'h6, 4'h0, 16'h0, 1'b0);
    w(OP_WR_VLOCK, 4'h5, 4'h0, 16'h0001, 1'b0);
    rc(OP_RD_VLOCK, 4'h5, 4'h0, 16'h0001);
    rc(OP_CHECK, 4'h5, 4'h0, 16'h0001);
    w(OP_WR_VLOCK, 4'h5, 4'h0, 16'h0003, 1'b0);
    w(OP_WR_VLOCK, 4'h5, 4'h0, 16'h0000, 1'b0);
    rc(OP_RD_VLOCK, 4'h5, 4'h0, 16'h0003);
    w(OP_WR_VLOCK, 4'h0, 4'h2, 16'h0001, 1'b0);
    rc(OP_RD_VLOCK, 4'h0, 4'h2, 16'h0001);
    rc(OP_CHECK, 4'h0, 4'h3, 16'h0000);
    w(OP_WR_VLOCK, 4'hf, 4'h1, 16'h0001, 1'b0);
    rc(OP_RD_VLOCK, 4'hf, 4'h1, 16'h0001);
    rc(OP_RD_VLOCK, 4'hf, 4'h0, 16'h0000);
    rst();
    rc(OP_RD_VLOCK, 4'h5, 4'h0, 16'h0000);
    rc(OP_RD_VLOCK, 4'h0, 4'h2, 16'h0000);
    rc(OP_RD_NVLOCK, 4'h6, 4'h0, 16'h0000);
    // scheme fixed right away, the plain variant first
    w(OP_WR_PROT, 4'h0, 4'h0, 16'hfff9, 1'b0);
    rc(OP_RD_PROT, 4'h0, 4'h0, 16'hffff);
    w(OP_WR_PROT, 4'h0, 4'h0, 16'hfffd, 1'b0);
    w(OP_WR_PROT, 4'h0, 4'h0, 16'hfffb, 1'b0);
    rc(OP_RD_PROT, 4'h0, 4'h0, 16'hfffd);
    w(OP_WR_NVLOCK, 4'h7, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h2);
    @(negedge mclk);
    nv_init = 1'b1;
    @(negedge mclk);
    nv_init = 1'b0;
    w(OP_WR_PROT, 4'h0, 4'h0, 16'hfffb, 1'b0);
    rc(OP_RD_PROT, 4'h0, 4'h0, 16'hfffb);
    check({16'h0, pwd_locked}, 17'h1);
    w(OP_WR_PROT, 4'h0, 4'h0, 16'hfff9, 1'b0);
    rc(OP_RD_PROT, 4'h0, 4'h0, 16'hfffb);
    w(OP_WR_PWD, 4'h0, 4'h0, 16'h5678, 1'b0);
    check({16'h0, ok}, 17'h0);
    rst();
    rc(OP_RD_FREEZE, 4'h0, 4'h0, 16'h0000);
    check({16'h0, freeze}, 17'h0);
    w(OP_UNLOCK, 4'h0, 4'h0, 16'h0, 1'b0);
    rc(OP_RD_FREEZE, 4'h0, 4'h0, 16'h0000);
    w(OP_WR_NVLOCK, 4'h2, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h0);
    w(OP_UNLOCK, 4'h0, 4'h0, 16'h0, 1'b1);
    rc(OP_RD_FREEZE, 4'h0, 4'h0, 16'h0001);
    check({16'h0, freeze}, 17'h1);
    w(OP_WR_NVLOCK, 4'h2, 4'h0, 16'h0, 1'b0);
    check(bc, 17'h2);
    conclude();
  end
endmodule

`default_nettype wire
